/* rtl/scb_map.vh */
// register map and link constants for the serial codec buffer and dma control
// assumes a 32-bit register port with byte offsets and a 128-bit serial frame
`ifndef SCB_MAP_VH
`define SCB_MAP_VH

// register byte offsets
`define SCB_OFF_TEL_HOLD 8'h70
`define SCB_OFF_SF0_CMD 8'h80
`define SCB_OFF_SF1_CMD 8'h84
`define SCB_OFF_SF0_STAT 8'h88
`define SCB_OFF_SF1_STAT 8'h8c
`define SCB_OFF_DMA_CTL 8'h90
`define SCB_OFF_MOD_CFG 8'h94
`define SCB_OFF_TEL_RX_START 8'h98
`define SCB_OFF_TEL_TX_START 8'h9c
`define SCB_OFF_SND_RX_START 8'ha0
`define SCB_OFF_SND_TX_START 8'ha4
`define SCB_OFF_BUF_SIZE 8'ha8

// dma control field positions
`define SCB_SND_ONE_SHOT 31
`define SCB_SND_RX_FIRST 30
`define SCB_SND_PTR_LSB 18
`define SCB_SND_RX_EN 17
`define SCB_SND_TX_EN 16
`define SCB_TEL_ONE_SHOT 15
`define SCB_TEL_RX_FIRST 14
`define SCB_TEL_PTR_LSB 2
`define SCB_TEL_RX_EN 1
`define SCB_TEL_TX_EN 0
// writable bits of the dma control word
`define SCB_DMA_CTL_WMASK 32'hc003_c003

// module configuration fields
`define SCB_CFG_ENABLE 0
`define SCB_CFG_TX_ROOM 8

// reset values
`define SCB_RST_WORD 32'h0000_0000
`define SCB_RST_PTR 12'h000

// link framing counts
`define SCB_FRAME_BITS 128
`define SCB_WORD_BITS 32
`define SCB_TEL_FIFO_DEPTH 16

`endif

/* rtl/scb_fifo.v */
// synchronous fifo with a registered output stage, valid/ready on both sides
// assumes one clock; a soft clear empties it without touching the storage
`timescale 1ns/10ps
module scb_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clock, // system clock
   input wire rst_n, // async reset, active low
   input wire clear, // sync flush
   input wire wr_valid, // write offer
   output wire wr_ready, // room for a word
   input wire [WIDTH-1:0] wr_data, // write word
   output wire rd_valid, // output word valid
   input wire rd_ready, // consumer takes word
   output wire [WIDTH-1:0] rd_data // output word, registered
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wptr_ff;
   reg [AW-1:0] rptr_ff;
   reg [AW:0] cnt_ff;
   reg out_valid_ff;
   reg [WIDTH-1:0] out_data_ff;
   wire push;
   wire pop_mem;

   assign wr_ready = (cnt_ff < DEPTH[AW:0]);
   assign push = wr_valid && wr_ready;
   // refill the output stage whenever it is empty or being taken
   assign pop_mem = (cnt_ff != {(AW+1){1'b0}}) && (!out_valid_ff || rd_ready);
   assign rd_valid = out_valid_ff;
   assign rd_data = out_data_ff;

   // storage has no reset, only the pointers matter
   always @(posedge clock) begin
      if (push) begin
         mem[wptr_ff] <= wr_data;
      end
   end

   // pointers, count and output register
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wptr_ff <= {AW{1'b0}};
         rptr_ff <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
         out_valid_ff <= 1'b0;
         out_data_ff <= {WIDTH{1'b0}};
      end else if (clear) begin
         wptr_ff <= {AW{1'b0}};
         rptr_ff <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
         out_valid_ff <= 1'b0;
      end else begin
         if (push) begin
            wptr_ff <= wptr_ff + 1'b1;
         end
         if (pop_mem) begin
            rptr_ff <= rptr_ff + 1'b1;
            out_data_ff <= mem[rptr_ff];
            out_valid_ff <= 1'b1;
         end else if (rd_ready) begin
            out_valid_ff <= 1'b0;
         end
         cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop_mem};
      end
   end
endmodule // scb_fifo

/* rtl/scb_ctrl.v */
// holds the register file, the framed serial link and the two dma sequencers
// assumes link pins come from outside the clock domain; dma port on same clock
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "scb_map.vh"
module scb_ctrl #(
   parameter PTR_W = 12, // dma counter width, address bits 13:2
   parameter FIFO_DEPTH = `SCB_TEL_FIFO_DEPTH // telecom transmit buffer depth
) (
   input wire clock, // 125 mhz system clock
   input wire rst_n, // async reset, active low
   input wire [7:0] reg_addr, // register byte address
   input wire [31:0] reg_wdata, // register write data
   input wire reg_wr, // write strobe
   input wire reg_rd, // read strobe
   output reg [31:0] reg_rdata, // read data, cycle after strobe
   input wire link_clk, // serial bit clock pin
   input wire link_sync, // frame sync pin, high with bit 0
   input wire link_din, // serial data from codec
   output reg link_dout, // serial data to codec
   output reg tel_sample_pulse, // telecom word received
   input wire snd_sample_tick, // sound sample event, same clock
   output wire [1:0] dma_req, // request per class, 0 tel, 1 snd
   output wire [1:0] dma_rx, // 1 write memory, 0 read memory
   output wire [31:0] tel_dma_addr, // telecom dma address
   output wire [31:0] snd_dma_addr, // sound dma address
   output reg [31:0] dma_wdata, // telecom receive word for memory
   input wire [1:0] dma_ack, // request completed
   input wire [31:0] dma_rdata // memory word on a read ack
);
   integer i;

   // register file
   reg [31:0] sf0_cmd_ff, sf1_cmd_ff, sf0_stat_ff, sf1_stat_ff, dma_ctl_ff;
   reg mod_en_ff;
   reg [31:0] tel_rx_start_ff, tel_tx_start_ff, snd_rx_start_ff, snd_tx_start_ff;
   reg [PTR_W-1:0] size_ff;
   reg [31:0] tel_rx_hold_ff, nxt_rdata;

   // link side
   reg [2:0] clk_sync_ff;
   reg [1:0] fs_sync_ff, din_sync_ff;
   reg [6:0] bcnt_ff;
   reg [31:0] tx_sr_ff, rx_sr_ff;
   reg tel_trig_ff;
   wire clk_rise;
   wire [6:0] pos;
   wire [31:0] rx_word;

   // dma sequencers, index 0 telecom, 1 sound
   reg [1:0] busy_ff, cur_rx_ff, rxp_ff, txp_ff, stop_ff;
   reg [2*PTR_W-1:0] ptr_ff;
   reg [63:0] dma_addr_ff;
   wire [1:0] trig, en_rx, en_tx, rx_first, one_shot, room;
   wire [PTR_W-1:0] tel_ptr, snd_ptr;

   // telecom transmit buffer
   wire fifo_wr_valid, fifo_wr_ready, fifo_rd_valid, fifo_rd_ready, tel_tx_dma_ack, cpu_tx_wr;
   wire [31:0] fifo_wr_data, fifo_rd_data;

   // memory address of word ptr inside a buffer
   function [31:0] buf_addr;
      input [31:0] start;
      input [PTR_W-1:0] ptr;
      begin
         buf_addr = start + {{(30-PTR_W){1'b0}}, ptr, 2'b00};
      end
   endfunction

   // register write decode
   function wr_hit;
      input [7:0] addr;
      input [7:0] off;
      begin
         wr_hit = reg_wr && (addr == off);
      end
   endfunction

   assign tel_ptr = ptr_ff[PTR_W-1:0];
   assign snd_ptr = ptr_ff[2*PTR_W-1:PTR_W];
   assign en_rx = {dma_ctl_ff[`SCB_SND_RX_EN], dma_ctl_ff[`SCB_TEL_RX_EN]};
   assign en_tx = {dma_ctl_ff[`SCB_SND_TX_EN], dma_ctl_ff[`SCB_TEL_TX_EN]};
   assign rx_first = {dma_ctl_ff[`SCB_SND_RX_FIRST], dma_ctl_ff[`SCB_TEL_RX_FIRST]};
   assign one_shot = {dma_ctl_ff[`SCB_SND_ONE_SHOT], dma_ctl_ff[`SCB_TEL_ONE_SHOT]};
   assign trig = {snd_sample_tick, tel_trig_ff};
   // telecom reads from memory stall while the transmit buffer is full
   assign room = {1'b1, fifo_wr_ready};
   assign dma_req = busy_ff;
   assign dma_rx = cur_rx_ff;
   assign tel_dma_addr = dma_addr_ff[31:0];
   assign snd_dma_addr = dma_addr_ff[63:32];

   // control and configuration registers; writes ignore frame timing
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sf0_cmd_ff <= `SCB_RST_WORD;
         sf1_cmd_ff <= `SCB_RST_WORD;
         dma_ctl_ff <= `SCB_RST_WORD;
         mod_en_ff <= 1'b0;
         tel_rx_start_ff <= `SCB_RST_WORD;
         tel_tx_start_ff <= `SCB_RST_WORD;
         snd_rx_start_ff <= `SCB_RST_WORD;
         snd_tx_start_ff <= `SCB_RST_WORD;
         size_ff <= `SCB_RST_PTR;
      end else begin
         if (reg_wr) begin
            case (reg_addr)
               `SCB_OFF_SF0_CMD: sf0_cmd_ff <= reg_wdata;
               `SCB_OFF_SF1_CMD: sf1_cmd_ff <= reg_wdata;
               `SCB_OFF_MOD_CFG: mod_en_ff <= reg_wdata[`SCB_CFG_ENABLE];
               `SCB_OFF_TEL_RX_START: tel_rx_start_ff <= reg_wdata;
               `SCB_OFF_TEL_TX_START: tel_tx_start_ff <= reg_wdata;
               `SCB_OFF_SND_RX_START: snd_rx_start_ff <= reg_wdata;
               `SCB_OFF_SND_TX_START: snd_tx_start_ff <= reg_wdata;
               `SCB_OFF_BUF_SIZE: size_ff <= reg_wdata[PTR_W-1:0];
               default: ;
            endcase
         end
         // a one-shot end drops the enables; a software write the same cycle wins
         if (!mod_en_ff) begin
            dma_ctl_ff <= dma_ctl_ff & ~{14'h0000, 2'b11, 14'h0000, 2'b11};
         end else if (wr_hit(reg_addr, `SCB_OFF_DMA_CTL)) begin
            dma_ctl_ff <= reg_wdata & `SCB_DMA_CTL_WMASK;
         end else begin
            if (stop_ff[0]) begin
               dma_ctl_ff[`SCB_TEL_RX_EN] <= 1'b0;
               dma_ctl_ff[`SCB_TEL_TX_EN] <= 1'b0;
            end
            if (stop_ff[1]) begin
               dma_ctl_ff[`SCB_SND_RX_EN] <= 1'b0;
               dma_ctl_ff[`SCB_SND_TX_EN] <= 1'b0;
            end
         end
      end
   end

   // read mux; unmapped addresses and write-only fields read zero
   always @* begin
      nxt_rdata = 32'h0000_0000;
      case (reg_addr)
         `SCB_OFF_TEL_HOLD: nxt_rdata = tel_rx_hold_ff;
         `SCB_OFF_SF0_CMD: nxt_rdata = sf0_cmd_ff;
         `SCB_OFF_SF1_CMD: nxt_rdata = sf1_cmd_ff;
         `SCB_OFF_SF0_STAT: nxt_rdata = sf0_stat_ff;
         `SCB_OFF_SF1_STAT: nxt_rdata = sf1_stat_ff;
         `SCB_OFF_DMA_CTL: begin
            nxt_rdata = dma_ctl_ff;
            nxt_rdata[`SCB_SND_PTR_LSB +: PTR_W] = snd_ptr;
            nxt_rdata[`SCB_TEL_PTR_LSB +: PTR_W] = tel_ptr;
         end
         `SCB_OFF_MOD_CFG: begin
            nxt_rdata[`SCB_CFG_ENABLE] = mod_en_ff;
            nxt_rdata[`SCB_CFG_TX_ROOM] = fifo_wr_ready;
         end
         `SCB_OFF_TEL_RX_START: nxt_rdata = tel_rx_start_ff;
         `SCB_OFF_TEL_TX_START: nxt_rdata = tel_tx_start_ff;
         `SCB_OFF_SND_RX_START: nxt_rdata = snd_rx_start_ff;
         `SCB_OFF_SND_TX_START: nxt_rdata = snd_tx_start_ff;
         `SCB_OFF_BUF_SIZE: nxt_rdata[PTR_W-1:0] = size_ff;
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   // read data stand one cycle after the strobe; receive word copied out for dma
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
         dma_wdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= reg_rd ? nxt_rdata : 32'h0000_0000;
         dma_wdata <= tel_rx_hold_ff;
      end
   end

   // pin synchronisers; only the second stage onward is looked at
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         clk_sync_ff <= 3'b000;
         fs_sync_ff <= 2'b00;
         din_sync_ff <= 2'b00;
      end else begin
         clk_sync_ff <= {clk_sync_ff[1:0], link_clk};
         fs_sync_ff <= {fs_sync_ff[0], link_sync};
         din_sync_ff <= {din_sync_ff[0], link_din};
      end
   end

   assign clk_rise = clk_sync_ff[1] && !clk_sync_ff[2];
   // bit position of this rising edge; sync marks bit 0 of the frame
   assign pos = fs_sync_ff[1] ? 7'd0 : bcnt_ff + 7'd1;
   assign rx_word = {rx_sr_ff[30:0], din_sync_ff[1]};

   // transmit buffer fed by cpu writes or dma reads, drained by the link
   assign tel_tx_dma_ack = dma_ack[0] && busy_ff[0] && !cur_rx_ff[0];
   assign cpu_tx_wr = wr_hit(reg_addr, `SCB_OFF_TEL_HOLD);
   assign fifo_wr_valid = tel_tx_dma_ack || cpu_tx_wr;
   assign fifo_wr_data = tel_tx_dma_ack ? dma_rdata : reg_wdata;
   assign fifo_rd_ready = mod_en_ff && clk_rise && (pos == 7'd32);

   scb_fifo #(
      .WIDTH(32),
      .DEPTH(FIFO_DEPTH),
      .AW(4)
   ) u_tx_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .clear(!mod_en_ff),
      .wr_valid(fifo_wr_valid),
      .wr_ready(fifo_wr_ready),
      .wr_data(fifo_wr_data),
      .rd_valid(fifo_rd_valid),
      .rd_ready(fifo_rd_ready),
      .rd_data(fifo_rd_data)
   );

   // serial frame: per subframe a 32-bit command/status field; telecom data follows in subframe 0 only, subframe 1 idles
   // command words are latched at field start, so a write never tears a word
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bcnt_ff <= 7'd0;
         tx_sr_ff <= `SCB_RST_WORD;
         rx_sr_ff <= `SCB_RST_WORD;
         link_dout <= 1'b0;
         sf0_stat_ff <= `SCB_RST_WORD;
         sf1_stat_ff <= `SCB_RST_WORD;
         tel_rx_hold_ff <= `SCB_RST_WORD;
         tel_trig_ff <= 1'b0;
         tel_sample_pulse <= 1'b0;
      end else if (!mod_en_ff) begin
         bcnt_ff <= 7'd0;
         tx_sr_ff <= `SCB_RST_WORD;
         rx_sr_ff <= `SCB_RST_WORD;
         link_dout <= 1'b0;
         tel_trig_ff <= 1'b0;
         tel_sample_pulse <= 1'b0;
      end else begin
         tel_trig_ff <= 1'b0;
         tel_sample_pulse <= 1'b0;
         if (clk_rise) begin
            bcnt_ff <= pos;
            rx_sr_ff <= rx_word;
            if (pos[4:0] == 5'd0) begin
               case (pos[6:5])
                  2'd0: begin
                     link_dout <= sf0_cmd_ff[31];
                     tx_sr_ff <= {sf0_cmd_ff[30:0], 1'b0};
                  end
                  2'd1: begin
                     // empty buffer sends a zero word
                     link_dout <= fifo_rd_valid & fifo_rd_data[31];
                     tx_sr_ff <= fifo_rd_valid ? {fifo_rd_data[30:0], 1'b0} : 32'h0000_0000;
                  end
                  2'd2: begin
                     link_dout <= sf1_cmd_ff[31];
                     tx_sr_ff <= {sf1_cmd_ff[30:0], 1'b0};
                  end
                  default: begin
                     link_dout <= 1'b0;
                     tx_sr_ff <= 32'h0000_0000;
                  end
               endcase
            end else begin
               link_dout <= tx_sr_ff[31];
               tx_sr_ff <= {tx_sr_ff[30:0], 1'b0};
            end
            // word complete on the last bit of a field
            if (pos[4:0] == 5'd31) begin
               case (pos[6:5])
                  2'd0: sf0_stat_ff <= rx_word;
                  2'd1: begin
                     tel_rx_hold_ff <= rx_word;
                     tel_trig_ff <= 1'b1;
                     tel_sample_pulse <= 1'b1;
                  end
                  2'd2: sf1_stat_ff <= rx_word;
                  default: tel_trig_ff <= 1'b0;
               endcase
            end
         end
      end
   end

   // dma sequencers: requests held until ack, order from the order bit,
   // counter advances once both directions of a sample are done
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy_ff <= 2'b00;
         cur_rx_ff <= 2'b00;
         rxp_ff <= 2'b00;
         txp_ff <= 2'b00;
         stop_ff <= 2'b00;
         ptr_ff <= {(2*PTR_W){1'b0}};
         dma_addr_ff <= 64'h0000_0000_0000_0000;
      end else if (!mod_en_ff) begin
         busy_ff <= 2'b00;
         cur_rx_ff <= 2'b00;
         rxp_ff <= 2'b00;
         txp_ff <= 2'b00;
         stop_ff <= 2'b00;
         ptr_ff <= {(2*PTR_W){1'b0}};
      end else begin
         for (i = 0; i < 2; i = i + 1) begin
            stop_ff[i] <= 1'b0;
            if (!busy_ff[i]) begin
               if (rxp_ff[i] && (rx_first[i] || !txp_ff[i])) begin
                  busy_ff[i] <= 1'b1;
                  cur_rx_ff[i] <= 1'b1;
                  dma_addr_ff[32*i +: 32] <= buf_addr(i == 0 ? tel_rx_start_ff : snd_rx_start_ff,
                     ptr_ff[PTR_W*i +: PTR_W]);
               end else if (txp_ff[i] && room[i]) begin
                  busy_ff[i] <= 1'b1;
                  cur_rx_ff[i] <= 1'b0;
                  dma_addr_ff[32*i +: 32] <= buf_addr(i == 0 ? tel_tx_start_ff : snd_tx_start_ff,
                     ptr_ff[PTR_W*i +: PTR_W]);
               end
            end else if (dma_ack[i]) begin
               busy_ff[i] <= 1'b0;
               if (cur_rx_ff[i]) begin
                  rxp_ff[i] <= 1'b0;
               end else begin
                  txp_ff[i] <= 1'b0;
               end
               if (cur_rx_ff[i] ? !txp_ff[i] : !rxp_ff[i]) begin
                  if (ptr_ff[PTR_W*i +: PTR_W] + 1'b1 >= size_ff) begin
                     ptr_ff[PTR_W*i +: PTR_W] <= {PTR_W{1'b0}};
                     stop_ff[i] <= one_shot[i];
                  end else begin
                     ptr_ff[PTR_W*i +: PTR_W] <= ptr_ff[PTR_W*i +: PTR_W] + 1'b1;
                  end
               end
            end
            // a new sample event wins over the clear above
            if (trig[i] && !stop_ff[i]) begin
               if (en_rx[i]) begin
                  rxp_ff[i] <= 1'b1;
               end
               if (en_tx[i]) begin
                  txp_ff[i] <= 1'b1;
               end
            end
         end
      end
   end
endmodule // scb_ctrl

/* testbench/scb_ctrl_monitor.sv */
// port-level checker for scb_ctrl: read port, dma handshake, link timing
// assumes it is bound onto every scb_ctrl instance, one clock domain
`timescale 1ns/10ps
module scb_ctrl_monitor (
   input wire clock, // system clock
   input wire rst_n, // async reset, active low
   input wire reg_rd, // read strobe
   input wire [31:0] reg_rdata, // read data
   input wire link_clk, // bit clock pin
   input wire link_dout, // serial data out
   input wire tel_sample_pulse, // telecom word event
   input wire [1:0] dma_req, // dma requests
   input wire [1:0] dma_rx, // dma direction
   input wire [1:0] dma_ack, // dma completions
   input wire [31:0] tel_dma_addr, // telecom address
   input wire [31:0] snd_dma_addr // sound address
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // request still waiting, and request being completed
   sequence s_wait(b);
      dma_req[b] && !dma_ack[b];
   endsequence
   sequence s_done(b);
      dma_req[b] && dma_ack[b];
   endsequence
   // pin seen high lately after a long low phase, i.e. a fresh rise
   sequence s_rise_seen;
      $past(link_clk, 1) && !$past(link_clk, 7);
   endsequence
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data not zero outside its slot");
   a_tel_hold: assert property (s_wait(0) |=> dma_req[0] && $stable(dma_rx[0]) && $stable(tel_dma_addr))
      else $error("telecom request changed before ack");
   a_snd_hold: assert property (s_wait(1) |=> dma_req[1] && $stable(dma_rx[1]) && $stable(snd_dma_addr))
      else $error("sound request changed before ack");
   a_tel_drop: assert property (s_done(0) |=> !dma_req[0])
      else $error("telecom request not dropped after ack");
   a_snd_drop: assert property (s_done(1) |=> !dma_req[1])
      else $error("sound request not dropped after ack");
   a_pulse_single: assert property (tel_sample_pulse |=> !tel_sample_pulse [*8])
      else $error("telecom sample pulse too long");
   a_dout_timing: assert property ($changed(link_dout) |-> s_rise_seen)
      else $error("serial out moved away from a bit clock rise");
   a_pulse_timing: assert property (tel_sample_pulse |-> s_rise_seen)
      else $error("telecom pulse not tied to a bit clock rise");
endmodule // scb_ctrl_monitor

bind scb_ctrl scb_ctrl_monitor i_mon (.clock, .rst_n, .reg_rd, .reg_rdata, .link_clk, .link_dout,
   .tel_sample_pulse, .dma_req, .dma_rx, .dma_ack, .tel_dma_addr, .snd_dma_addr);

/* testbench/scb_codec_model.sv */
// behavioural codec on the far side of the framed serial link
// assumes 125 ns bit clock that stands low between frames
`timescale 1ns/10ps
module scb_codec_model (
   output reg link_clk, // bit clock, still outside frames
   output reg link_sync, // high with bit 0
   output reg link_din, // status and telecom data out
   input wire link_dout // command and telecom data in
);
   reg [127:0] rx_word; // last frame seen on dout, msb first
   initial begin
      link_clk = 1'b0;
      link_sync = 1'b0;
      link_din = 1'b0;
      rx_word = {128{1'b0}};
   end
   // one frame: sf0 status, telecom word, sf1 status, idle quarter
   task frame(input [31:0] s0, input [31:0] t, input [31:0] s1);
      reg [127:0] tx;
      integer i;
      begin
         tx = {s0, t, s1, 32'h0000_0000};
         for (i = 0; i < 128; i = i + 1) begin
            link_din = tx[127-i];
            link_sync = (i == 0);
            #62.5 link_clk = 1'b1;
            #62.5 rx_word = {rx_word[126:0], link_dout};
            link_clk = 1'b0;
         end
         link_sync = 1'b0;
         link_din = ~link_din; // released line shows no stale value
      end
   endtask
endmodule // scb_codec_model

/* testbench/serial_codec_buffer_and_dma_control_tb.sv */
// self-checking bench for scb_ctrl with a codec model on the link
// assumes register offsets and field positions of scb_map.vh
`timescale 1ns/10ps
module serial_codec_buffer_and_dma_control_tb;
   reg clock = 1'b0;
   reg rst_n = 1'b0;
   reg [7:0] reg_addr = 8'h00;
   reg [31:0] reg_wdata = 32'h0000_0000;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg snd_sample_tick = 1'b0;
   reg [1:0] dma_ack = 2'b00;
   reg [31:0] dma_rdata = 32'h0000_0000;
   wire [31:0] reg_rdata, tel_dma_addr, snd_dma_addr, dma_wdata;
   wire [1:0] dma_req, dma_rx;
   wire link_clk, link_sync, link_din, link_dout, tel_sample_pulse;
   integer err_count = 0;
   integer n_compared = 0;
   // 125 mhz system clock
   always #4 clock = ~clock;
   scb_ctrl i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk), .link_sync(link_sync), .link_din(link_din),
      .link_dout(link_dout), .tel_sample_pulse(tel_sample_pulse), .snd_sample_tick(snd_sample_tick),
      .dma_req(dma_req), .dma_rx(dma_rx), .tel_dma_addr(tel_dma_addr), .snd_dma_addr(snd_dma_addr),
      .dma_wdata(dma_wdata), .dma_ack(dma_ack), .dma_rdata(dma_rdata));
   scb_codec_model i_codec (.link_clk(link_clk), .link_sync(link_sync), .link_din(link_din), .link_dout(link_dout));
   task check(input string name, input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clock);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge clock);
         reg_wr <= 1'b0;
      end
   endtask
   // read data stands only in the cycle after the strobe
   task rdc(input [7:0] a, input [31:0] exp, input string name);
      begin
         @(posedge clock);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge clock);
         reg_rd <= 1'b0;
         #1 check(name, reg_rdata, exp);
      end
   endtask
   // wait bounded for a request, judge it, ack one cycle
   task serve(input integer b, input rx, input [31:0] addr, input [31:0] d);
      integer i;
      begin
         // a request dropped at the caller's edge is still up until that edge settles
         i = 0;
         @(posedge clock);
         #1;
         while (i < 3000 && dma_req[b] !== 1'b1) begin
            @(posedge clock);
            #1;
            i = i + 1;
         end
         check("dma_req", {31'h0000_0000, dma_req[b]}, 32'h0000_0001);
         check("dma_rx", {31'h0000_0000, dma_rx[b]}, {31'h0000_0000, rx});
         check("dma_addr", b ? snd_dma_addr : tel_dma_addr, addr);
         @(posedge clock);
         dma_ack[b] <= 1'b1;
         dma_rdata <= d;
         @(posedge clock);
         dma_ack[b] <= 1'b0;
      end
   endtask
   task tick;
      begin
         @(posedge clock);
         snd_sample_tick <= 1'b1;
         @(posedge clock);
         snd_sample_tick <= 1'b0;
      end
   endtask
   task t_regs;
      begin
         rdc(8'h90, 32'h0000_0000, "dma_ctl");
         wr(8'h88, 32'hffff_ffff);
         rdc(8'h88, 32'h0000_0000, "sf0_stat");
         rdc(8'h3c, 32'h0000_0000, "unmapped");
         $display("test regs done");
      end
   endtask
   task t_link;
      begin
         wr(8'h94, 32'h0000_0001);
         wr(8'h80, 32'ha5c3_0f81);
         wr(8'h84, 32'h5e1d_7b24);
         wr(8'h70, 32'hc0de_1357);
         i_codec.frame(32'h1234_5678, 32'h8765_4321, 32'h0f0f_e1e1);
         check("sf0_cmd", i_codec.rx_word[127:96], 32'ha5c3_0f81);
         check("tel_tx", i_codec.rx_word[95:64], 32'hc0de_1357);
         check("sf1_cmd", i_codec.rx_word[63:32], 32'h5e1d_7b24);
         rdc(8'h88, 32'h1234_5678, "sf0_stat");
         rdc(8'h8c, 32'h0f0f_e1e1, "sf1_stat");
         rdc(8'h70, 32'h8765_4321, "tel_rx");
         fork
            i_codec.frame(32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
            begin
               repeat (1000) @(posedge clock);
               wr(8'h80, 32'h3366_99cc);
            end
         join
         check("sf0_cmd", i_codec.rx_word[127:96], 32'ha5c3_0f81);
         check("sf1_cmd", i_codec.rx_word[63:32], 32'h5e1d_7b24);
         i_codec.frame(32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
         check("sf0_cmd", i_codec.rx_word[127:96], 32'h3366_99cc);
         $display("test link done");
      end
   endtask
   task t_dma;
      begin
         wr(8'ha8, 32'h0000_0002);
         wr(8'h98, 32'h0000_0100);
         wr(8'h9c, 32'h0000_0200);
         wr(8'ha0, 32'h0000_0300);
         wr(8'ha4, 32'h0000_0400);
         wr(8'h90, 32'h8003_4003);
         tick;
         serve(1, 1'b0, 32'h0000_0400, 32'h0000_0000);
         serve(1, 1'b1, 32'h0000_0300, 32'h0000_0000);
         rdc(8'h90, 32'h8007_4003, "dma_ctl");
         wr(8'h90, 32'hc003_4003);
         tick;
         serve(1, 1'b1, 32'h0000_0304, 32'h0000_0000);
         serve(1, 1'b0, 32'h0000_0404, 32'h0000_0000);
         rdc(8'h90, 32'hc000_4003, "dma_ctl");
         fork
            i_codec.frame(32'h0000_0000, 32'hbeef_0042, 32'h0000_0000);
            begin
               serve(0, 1'b1, 32'h0000_0100, 32'h0000_0000);
               check("dma_wdata", dma_wdata, 32'hbeef_0042);
               serve(0, 1'b0, 32'h0000_0200, 32'h7a7a_1c1c);
            end
         join
         rdc(8'h90, 32'hc000_4007, "dma_ctl");
         wr(8'h90, 32'hc000_0003);
         fork
            i_codec.frame(32'h0000_0000, 32'h0bad_cafe, 32'h0000_0000);
            begin
               serve(0, 1'b0, 32'h0000_0204, 32'h0000_0000);
               serve(0, 1'b1, 32'h0000_0104, 32'h0000_0000);
            end
         join
         check("tel_tx", i_codec.rx_word[95:64], 32'h7a7a_1c1c);
         rdc(8'h90, 32'hc000_0003, "dma_ctl");
         $display("test dma done");
      end
   endtask
   task t_off;
      begin
         wr(8'h94, 32'h0000_0000);
         rdc(8'h90, 32'hc000_0000, "dma_ctl");
         i_codec.frame(32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
         check("sf0_cmd", i_codec.rx_word[127:96], 32'h0000_0000);
         $display("test off done");
      end
   endtask
   task report_and_stop;
      begin
         $display("compared %0d mismatches %0d", n_compared, err_count);
         if (err_count == 0 && n_compared > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // main sequence after 12 cycles of reset
   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      t_regs;
      t_link;
      t_dma;
      t_off;
      report_and_stop;
   end
   // watchdog, well beyond six frames of 16 us
   initial begin
      #400_000;
      err_count = err_count + 1;
      report_and_stop;
   end
endmodule // serial_codec_buffer_and_dma_control_tb
